// *** src/iohn_params.svh ***
/*
 * Constants of the I/O address and order map: register offsets,
 * configuration field positions, write masks, reset values, shifts.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef IOHN_PARAMS_SVH
`define IOHN_PARAMS_SVH

`define IOHN_ADDR_W        52
`define IOHN_REG_AW        8
`define IOHN_DATA_W        64
`define IOHN_NUM_REG       4
`define IOHN_NUM_ENT       4
`define IOHN_IDX_W         2
`define IOHN_TAG_W         54
`define IOHN_SHIFT_W       7
`define IOHN_CNT_W         16

`define IOHN_OFF_CFG0      8'h00
`define IOHN_OFF_CFG1      8'h08
`define IOHN_OFF_CFG2      8'h10
`define IOHN_OFF_CFG3      8'h18
`define IOHN_OFF_STATUS    8'h20
`define IOHN_OFF_COUNT     8'h28

`define IOHN_BIT_VALID     63
`define IOHN_BIT_EARLY_WR  62
`define IOHN_BIT_EARLY_RD  61
`define IOHN_BIT_SER_DEV   60
`define IOHN_BIT_SER_ALL   59
`define IOHN_BIT_PHYS      58
`define IOHN_BASE_HI       55
`define IOHN_BASE_LO       16
`define IOHN_RSZ_HI        15
`define IOHN_RSZ_LO        10
`define IOHN_OSZ_HI        5
`define IOHN_OSZ_LO        0

`define IOHN_WMASK_CFG0    64'h7C00_0000_0000_003F
`define IOHN_WMASK_CFGN    64'hFCFF_FFFF_FFFF_FC3F
`define IOHN_RST_CFG0      64'h0000_0000_0000_003F
`define IOHN_RST_CFGN      64'h0000_0000_0000_0000

`define IOHN_OSZ_ALL       6'h3F
`define IOHN_GRAN_SHIFT    7'h0C
`define IOHN_LINE_SHIFT    7'h06
`define IOHN_SHIFT_ALL     7'h7F
`define IOHN_GRAN_ZERO     12'h000

`endif

// *** src/iohn_pkg.sv ***
/*
 * Types of the I/O address and order map: the registered state of
 * the top module. Assumes the parameter header is on the include path.
 */
`include "iohn_params.svh"

package iohn_pkg;

    typedef logic [`IOHN_TAG_W-1:0] iohn_tag_t;

    typedef struct packed {
        logic [`IOHN_NUM_REG-1:0][`IOHN_DATA_W-1:0] cfg;
        logic [`IOHN_NUM_REG-1:0][`IOHN_CNT_W-1:0]  hit_cnt;
        logic [`IOHN_DATA_W-1:0]                    rdata;
        logic                                       ready;
        logic [`IOHN_NUM_ENT-1:0]                   ent_valid;
        logic [`IOHN_NUM_ENT-1:0]                   ent_tail;
        logic [`IOHN_NUM_ENT-1:0][`IOHN_TAG_W-1:0]  ent_tag;
        logic [`IOHN_IDX_W-1:0]                     last_region;
        logic                                       disp_valid;
        logic [`IOHN_IDX_W-1:0]                     disp_region;
        logic [`IOHN_IDX_W-1:0]                     disp_idx;
        logic [`IOHN_TAG_W-1:0]                     disp_tag;
        logic                                       disp_phys;
        logic                                       disp_bypass;
        logic                                       disp_dep_valid;
        logic [`IOHN_IDX_W-1:0]                     disp_dep_idx;
        logic                                       disp_early_wr;
        logic                                       disp_early_rd;
        logic                                       disp_ser_dev;
        logic                                       disp_ser_all;
    } iohn_state_s;

endpackage

// *** src/iohn_region_match.sv ***
/*
 * Address match and order index for one address region.
 * Assumes a configuration word in the region layout; purely
 * combinational, the caller registers its results.
 */
`include "iohn_params.svh"
`timescale 1ns/1ps
`default_nettype none

module iohn_region_match (
    input  wire logic [`IOHN_DATA_W-1:0] cfg_in,
    input  wire logic [`IOHN_ADDR_W-1:0] addr_in,
    input  wire logic                    default_in,
    output logic                         hit_out,
    output logic [`IOHN_ADDR_W-1:0]      order_idx_out
);

    logic [`IOHN_ADDR_W-1:0]  base;
    logic [`IOHN_ADDR_W-1:0]  offset;
    logic [`IOHN_SHIFT_W-1:0] region_shift;
    logic [`IOHN_SHIFT_W-1:0] order_shift;
    logic [5:0]               order_code;
    logic                     in_range;

    // Base in 4KB granules; the default region starts at zero
    assign base = default_in ? '0 :
        {cfg_in[`IOHN_BASE_HI:`IOHN_BASE_LO], `IOHN_GRAN_ZERO};
    assign offset = addr_in - base;
    assign region_shift = `IOHN_SHIFT_W'(cfg_in[`IOHN_RSZ_HI:`IOHN_RSZ_LO])
        + `IOHN_GRAN_SHIFT;
    assign in_range = (addr_in >= base) && ((offset >> region_shift) == '0);
    // Region 0 takes every address; others need their valid bit
    assign hit_out = default_in
        || (cfg_in[`IOHN_BIT_VALID] && in_range);

    assign order_code = cfg_in[`IOHN_OSZ_HI:`IOHN_OSZ_LO];
    // Index counted from the base, so boundaries sit at base plus k spans
    always_comb begin
        if (cfg_in[`IOHN_BIT_PHYS]) begin
            order_shift = `IOHN_LINE_SHIFT;
        end else if (order_code == `IOHN_OSZ_ALL) begin
            order_shift = `IOHN_SHIFT_ALL;
        end else begin
            order_shift = `IOHN_SHIFT_W'(order_code)
                + `IOHN_GRAN_SHIFT;
        end
    end
    assign order_idx_out = offset >> order_shift;

endmodule

`default_nettype wire

// *** src/iohn_order_map.sv ***
/*
 * I/O home node address map and ordering tracker: four region
 * configuration words, region match, order tags and an in-flight
 * table that chains requests with equal tags.
 * Assumes requests and completions come from logic on clk_in and that
 * software keeps regions 1 to 3 disjoint.
 */
`include "iohn_params.svh"
`timescale 1ns/1ps
`default_nettype none

module iohn_order_map (
    input  wire logic                    clk_in,
    input  wire logic                    arst_n_in,
    input  wire logic [`IOHN_REG_AW-1:0] reg_addr_in,
    input  wire logic [`IOHN_DATA_W-1:0] reg_wdata_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    output logic [`IOHN_DATA_W-1:0]      reg_rdata_out,
    input  wire logic                    req_valid_in,
    input  wire logic [`IOHN_ADDR_W-1:0] req_addr_in,
    input  wire logic                    req_pcie_src_in,
    output logic                         req_ready_out,
    input  wire logic                    done_valid_in,
    input  wire logic [`IOHN_IDX_W-1:0]  done_idx_in,
    output logic                         disp_valid_out,
    output logic [`IOHN_IDX_W-1:0]       disp_region_out,
    output logic [`IOHN_IDX_W-1:0]       disp_idx_out,
    output logic [`IOHN_TAG_W-1:0]       disp_tag_out,
    output logic                         disp_phys_out,
    output logic                         disp_bypass_out,
    output logic                         disp_dep_valid_out,
    output logic [`IOHN_IDX_W-1:0]       disp_dep_idx_out,
    output logic                         disp_early_wr_out,
    output logic                         disp_early_rd_out,
    output logic                         disp_ser_dev_out,
    output logic                         disp_ser_all_out
);

    iohn_pkg::iohn_state_s st;
    iohn_pkg::iohn_state_s next_st;

    logic [`IOHN_NUM_REG-1:0]                   hit;
    logic [`IOHN_NUM_REG-1:0][`IOHN_ADDR_W-1:0] order_idx;

    // Byte offset of a configuration word
    function automatic logic [`IOHN_REG_AW-1:0] cfg_off(
        input int unsigned idx
    );
        logic [`IOHN_REG_AW-1:0] off;
        case (idx)
            0: off = `IOHN_OFF_CFG0;
            1: off = `IOHN_OFF_CFG1;
            2: off = `IOHN_OFF_CFG2;
            default: off = `IOHN_OFF_CFG3;
        endcase
        return off;
    endfunction

    // Writable bits of a configuration word
    function automatic logic [`IOHN_DATA_W-1:0] cfg_mask(
        input int unsigned idx
    );
        logic [`IOHN_DATA_W-1:0] m;
        if (idx == 0) begin
            m = `IOHN_WMASK_CFG0;
        end else begin
            m = `IOHN_WMASK_CFGN;
        end
        return m;
    endfunction

    // Lowest free entry of the in-flight table
    function automatic logic [`IOHN_IDX_W-1:0] first_free(
        input logic [`IOHN_NUM_ENT-1:0] used
    );
        logic [`IOHN_IDX_W-1:0] f;
        f = '0;
        for (int e = `IOHN_NUM_ENT - 1; e >= 0; e--) begin
            if (!used[e]) begin
                f = `IOHN_IDX_W'(e);
            end
        end
        return f;
    endfunction

    genvar g;
    generate
        for (g = 0; g < `IOHN_NUM_REG; g++) begin : g_match
            iohn_region_match u_match (
                .cfg_in        (st.cfg[g]),
                .addr_in       (req_addr_in),
                .default_in    (g == 0),
                .hit_out       (hit[g]),
                .order_idx_out (order_idx[g])
            );
        end
    endgenerate

    always_comb begin
        logic [`IOHN_IDX_W-1:0]  sel;
        logic [`IOHN_IDX_W-1:0]  slot;
        logic [`IOHN_TAG_W-1:0]  tag;
        logic [`IOHN_DATA_W-1:0] sel_cfg;
        logic                    take;
        sel = '0;
        slot = '0;
        tag = '0;
        sel_cfg = '0;
        take = 1'b0;
        next_st = st;

        // Register read, data valid in the following cycle only
        next_st.rdata = '0;
        if (reg_rd_in) begin
            for (int r = 0; r < `IOHN_NUM_REG; r++) begin
                if (reg_addr_in == cfg_off(r)) begin
                    next_st.rdata = st.cfg[r];
                end
            end
            if (reg_addr_in == `IOHN_OFF_STATUS) begin
                next_st.rdata = {{(`IOHN_DATA_W - 10){1'b0}},
                                 st.last_region,
                                 st.ent_tail,
                                 st.ent_valid};
            end
            if (reg_addr_in == `IOHN_OFF_COUNT) begin
                next_st.rdata = st.hit_cnt;
            end
        end

        // Register write; fixed and reserved bits stay zero
        if (reg_wr_in) begin
            for (int r = 0; r < `IOHN_NUM_REG; r++) begin
                if (reg_addr_in == cfg_off(r)) begin
                    next_st.cfg[r] = reg_wdata_in & cfg_mask(r);
                end
            end
            if (reg_addr_in == `IOHN_OFF_COUNT) begin
                next_st.hit_cnt = '0;
            end
        end

        // Completion frees its entry; an idle entry ignores it
        if (done_valid_in) begin
            next_st.ent_valid[done_idx_in] = 1'b0;
            next_st.ent_tail[done_idx_in] = 1'b0;
        end

        // Valid and dependency outputs clear each cycle unless a request is taken
        next_st.disp_valid = 1'b0;
        next_st.disp_dep_valid = 1'b0;
        next_st.disp_dep_idx = '0;
        take = req_valid_in && st.ready;

        // Lower numbered valid region wins; zero only when none hits
        for (int r = `IOHN_NUM_REG - 1; r >= 1; r--) begin
            if (hit[r]) begin
                sel = `IOHN_IDX_W'(r);
            end
        end
        sel_cfg = st.cfg[sel];
        tag = {sel, order_idx[sel]};

        if (take) begin
            next_st.disp_valid = 1'b1;
            if (req_pcie_src_in) begin
                // Endpoint space, downstream applies PCIe ordering
                next_st.disp_bypass = 1'b1;
                next_st.disp_region = '0;
                next_st.disp_idx = '0;
                next_st.disp_tag = '0;
                next_st.disp_phys = 1'b0;
                next_st.disp_early_wr = 1'b0;
                next_st.disp_early_rd = 1'b0;
                next_st.disp_ser_dev = 1'b0;
                next_st.disp_ser_all = 1'b0;
            end else begin
                next_st.disp_bypass = 1'b0;
                next_st.disp_region = sel;
                next_st.disp_tag = tag;
                next_st.disp_phys = sel_cfg[`IOHN_BIT_PHYS];
                next_st.disp_early_wr = sel_cfg[`IOHN_BIT_EARLY_WR];
                next_st.disp_early_rd = sel_cfg[`IOHN_BIT_EARLY_RD];
                next_st.disp_ser_dev = sel_cfg[`IOHN_BIT_SER_DEV];
                next_st.disp_ser_all = sel_cfg[`IOHN_BIT_SER_ALL];
                next_st.last_region = sel;
                // Built on next_st so a hit in a clearing cycle still counts
                next_st.hit_cnt[sel] = next_st.hit_cnt[sel] + `IOHN_CNT_W'(1);

                // Chain behind the newest live entry with the same tag;
                // differing tags never wait on one another
                for (int e = 0; e < `IOHN_NUM_ENT; e++) begin
                    if (next_st.ent_valid[e] && st.ent_tail[e]
                            && st.ent_tag[e] == tag) begin
                        next_st.disp_dep_valid = 1'b1;
                        next_st.disp_dep_idx = `IOHN_IDX_W'(e);
                        next_st.ent_tail[e] = 1'b0;
                    end
                end

                // A slot freed this cycle may be reused at once
                slot = first_free(next_st.ent_valid);
                next_st.disp_idx = slot;
                next_st.ent_valid[slot] = 1'b1;
                next_st.ent_tail[slot] = 1'b1;
                next_st.ent_tag[slot] = tag;
            end
        end

        // Ready held in a flop; a slot is always free when it is high
        next_st.ready = ~&next_st.ent_valid;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
            st.cfg[0] <= `IOHN_RST_CFG0;
            st.cfg[1] <= `IOHN_RST_CFGN;
            st.cfg[2] <= `IOHN_RST_CFGN;
            st.cfg[3] <= `IOHN_RST_CFGN;
            st.ready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign req_ready_out = st.ready;
    assign disp_valid_out = st.disp_valid;
    assign disp_region_out = st.disp_region;
    assign disp_idx_out = st.disp_idx;
    assign disp_tag_out = st.disp_tag;
    assign disp_phys_out = st.disp_phys;
    assign disp_bypass_out = st.disp_bypass;
    assign disp_dep_valid_out = st.disp_dep_valid;
    assign disp_dep_idx_out = st.disp_dep_idx;
    assign disp_early_wr_out = st.disp_early_wr;
    assign disp_early_rd_out = st.disp_early_rd;
    assign disp_ser_dev_out = st.disp_ser_dev;
    assign disp_ser_all_out = st.disp_ser_all;

endmodule

`default_nettype wire

// *** dv/iohn_order_map_chk.sv ***
/* Port checker for the order map.
   Assumes a bind to iohn_order_map, one clock, async low reset. */
`include "iohn_params.svh"
`timescale 1ns/1ps
`default_nettype none
module iohn_order_map_chk (
    input wire logic                    clk_in,
    input wire logic                    arst_n_in,
    input wire logic                    reg_rd_in,
    input wire logic [`IOHN_DATA_W-1:0] reg_rdata_out,
    input wire logic                    req_valid_in,
    input wire logic                    req_pcie_src_in,
    input wire logic                    req_ready_out,
    input wire logic                    disp_valid_out,
    input wire logic [`IOHN_IDX_W-1:0]  disp_region_out,
    input wire logic [`IOHN_IDX_W-1:0]  disp_idx_out,
    input wire logic [`IOHN_TAG_W-1:0]  disp_tag_out,
    input wire logic                    disp_phys_out,
    input wire logic                    disp_bypass_out,
    input wire logic                    disp_dep_valid_out,
    input wire logic [`IOHN_IDX_W-1:0]  disp_dep_idx_out,
    input wire logic                    disp_early_wr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire take = req_valid_in && req_ready_out;
    property p_answer; take |=> disp_valid_out; endproperty
    a_answer: assert property (p_answer)
        else $error("no dispatch after take");
    property p_quiet;
        !take |=> !disp_valid_out && !disp_dep_valid_out;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("dispatch without take");
    property p_hold;
        !take |=> $stable(disp_tag_out) && $stable(disp_region_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("dispatch fields moved");
    property p_bypass;
        take && req_pcie_src_in |=> disp_bypass_out
            && disp_region_out == 2'h0 && !disp_dep_valid_out;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass request mapped");
    property p_bypass_flags;
        disp_valid_out && disp_bypass_out |-> !disp_phys_out
            && !disp_early_wr_out && disp_tag_out == '0;
    endproperty
    a_bypass_flags: assert property (p_bypass_flags)
        else $error("bypass carries region data");
    property p_tag_region;
        disp_valid_out && !disp_bypass_out
            |-> disp_tag_out[53:52] == disp_region_out;
    endproperty
    a_tag_region: assert property (p_tag_region)
        else $error("tag region field wrong");
    property p_dep_self;
        disp_dep_valid_out |-> disp_valid_out
            && disp_dep_idx_out != disp_idx_out;
    endproperty
    a_dep_self: assert property (p_dep_self)
        else $error("dependency on own entry");
    property p_rdata; !reg_rd_in |=> reg_rdata_out == '0; endproperty
    a_rdata: assert property (p_rdata)
        else $error("read data outside read slot");
endmodule
`default_nettype wire

// *** dv/iohn_req_node.sv ***
/* Request node model: issues one request and holds it until taken.
   Assumes the bench pulses issue_in only while idle. */
`timescale 1ns/1ps
`default_nettype none
module iohn_req_node (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        issue_in,
    input  wire logic [51:0] issue_addr_in,
    input  wire logic        issue_pcie_in,
    input  wire logic        ready_in,
    output logic             valid_out,
    output logic [51:0]      addr_out,
    output logic             pcie_out
);
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            valid_out <= 1'b0;
            addr_out  <= 52'h0;
            pcie_out  <= 1'b0;
        end else if (valid_out && ready_in) begin
            valid_out <= 1'b0;
            // Stale address must not look valid
            addr_out  <= ~addr_out;
        end else if (issue_in) begin
            valid_out <= 1'b1;
            addr_out  <= issue_addr_in;
            pcie_out  <= issue_pcie_in;
        end
    end
endmodule
`default_nettype wire

// *** dv/test_iohn_order_map.sv ***
/* Bench for the order map: register access and ordering scenarios.
   Assumes the request node model and the port checker. */
`timescale 1ns/1ps
`default_nettype none
module test_iohn_order_map;
    logic clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, iss = 0, ip = 0;
    logic rv, rp, rdy, dv = 0, dvl, dpv, ph, bp, ew, er, sd, sa;
    logic [7:0]  ra = 8'h00;
    logic [63:0] wd = 64'h0, rdat;
    logic [51:0] ia = 52'h0, rad;
    logic [1:0]  di = 2'h0, rg, ix, dix, a, b, c;
    logic [53:0] tg;
    logic [51:0] bs [4] = '{52'h0, 52'h2000, 52'h20000, 52'h200000};
    int          sh [4] = '{64, 6, 64, 15};
    logic [5:0]  fl [4] = '{6'b001100, 6'b101100, 6'b001100, 6'b001111};
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    iohn_req_node iohn_req_node_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .issue_in(iss), .issue_addr_in(ia), .issue_pcie_in(ip),
        .ready_in(rdy), .valid_out(rv), .addr_out(rad), .pcie_out(rp));
    iohn_order_map iohn_order_map_inst (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
        .req_valid_in(rv), .req_addr_in(rad), .req_pcie_src_in(rp),
        .req_ready_out(rdy), .done_valid_in(dv), .done_idx_in(di),
        .disp_valid_out(dvl), .disp_region_out(rg), .disp_idx_out(ix),
        .disp_tag_out(tg), .disp_phys_out(ph), .disp_bypass_out(bp),
        .disp_dep_valid_out(dpv), .disp_dep_idx_out(dix),
        .disp_early_wr_out(ew), .disp_early_rd_out(er),
        .disp_ser_dev_out(sd), .disp_ser_all_out(sa));
    task automatic end_sim;
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wreg(logic [7:0] ad, logic [63:0] d);
        @(posedge clk_in); ra <= ad; wd <= d; wr <= 1'b1;
        @(posedge clk_in); wr <= 1'b0;
    endtask
    task automatic rreg(logic [7:0] ad, logic [63:0] e);
        @(posedge clk_in); ra <= ad; rd <= 1'b1;
        @(posedge clk_in); rd <= 1'b0;
        #1 chk("rdata", e, rdat);
    endtask
    // Sends one request; checks mapping and returns the entry used
    task automatic req(logic [51:0] ad, logic p, logic [1:0] r, logic d,
                       logic [1:0] dp, output logic [1:0] got);
        logic [53:0] et;
        et = p ? 54'h0 : {r, 52'((ad - bs[r]) >> sh[r])};
        @(posedge clk_in); iss <= 1'b1; ia <= ad; ip <= p;
        @(posedge clk_in); iss <= 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_in); #1;
            if (dvl === 1'b1) break;
        end
        chk("disp_valid", 1, dvl);
        chk("region", r, rg);
        chk("tag", et, tg);
        chk("flags", p ? 6'b010000 : fl[r],
            {ph, bp, ew, er, sd, sa});
        chk("dep", {d, d ? dp : 2'h0}, {dpv, dix});
        got = ix;
    endtask
    task automatic free_all;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in); dv <= 1'b1; di <= 2'(i);
        end
        @(posedge clk_in); dv <= 1'b0;
        @(posedge clk_in); #1 chk("ready", 1, rdy);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk_in);
        arst_n_in <= 1'b1;
        rreg(8'h00, 64'h0000_0000_0000_003F);
        rreg(8'h08, 64'h0);
        rreg(8'h18, 64'h0);
        rreg(8'h30, 64'h0);
        wreg(8'h00, 64'hFFFF_FFFF_FFFF_FFFF);
        rreg(8'h00, 64'h7C00_0000_0000_003F);
        wreg(8'h00, 64'h6000_0000_0000_003F);
        wreg(8'h08, 64'hE400_0000_0002_0401);
        wreg(8'h10, 64'hE000_0000_0020_143F);
        wreg(8'h18, 64'hF800_0000_0200_2003);
        rreg(8'h08, 64'hE400_0000_0002_0401);
        req(52'h200000, 0, 3, 0, 0, a);
        req(52'h207FC0, 0, 3, 1, a, b);
        req(52'h208000, 0, 3, 0, 0, c);
        req(52'h2F8000, 0, 3, 0, 0, b);
        chk("ready", 0, rdy);
        // Status: last region 3, tails 1110, all four entries live
        rreg(8'h20, 64'h0000_0000_0000_03EF);
        free_all();
        rreg(8'h20, 64'h0000_0000_0000_0300);
        req(52'h2000, 0, 1, 0, 0, a);
        req(52'h2040, 0, 1, 0, 0, b);
        req(52'h2000, 0, 1, 1, a, c);
        free_all();
        req(52'h20000, 0, 2, 0, 0, a);
        req(52'h3F000, 0, 2, 1, a, b);
        req(52'h40000, 0, 0, 0, 0, c);
        req(52'h0, 0, 0, 1, c, a);
        free_all();
        req(52'h2000, 1, 0, 0, 0, a);
        wreg(8'h08, 64'h6400_0000_0002_0401);
        req(52'h2000, 0, 0, 0, 0, a);
        // Hits: region 3 four, region 2 two, regions 1 and 0 three
        rreg(8'h28, 64'h0004_0002_0003_0003);
        wreg(8'h28, 64'h0000_0000_0000_0000);
        rreg(8'h28, 64'h0000_0000_0000_0000);
        end_sim();
    end
endmodule
bind iohn_order_map iohn_order_map_chk iohn_order_map_chk_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .req_valid_in(req_valid_in),
    .req_pcie_src_in(req_pcie_src_in), .req_ready_out(req_ready_out),
    .disp_valid_out(disp_valid_out), .disp_region_out(disp_region_out),
    .disp_idx_out(disp_idx_out), .disp_tag_out(disp_tag_out),
    .disp_phys_out(disp_phys_out), .disp_bypass_out(disp_bypass_out),
    .disp_dep_valid_out(disp_dep_valid_out),
    .disp_dep_idx_out(disp_dep_idx_out),
    .disp_early_wr_out(disp_early_wr_out));
`default_nettype wire
